/* rtl/ssf_status.sv */
`timescale 1ns/100ps

// Contract
// - rx element count at bits 28-24
// - tx element count at bits 20-16
// - frame error flag bit 12, sticky
// - activity flag bit 11 while busy
// - underrun flag bit 8, framed mode
// - shifter empty flag at bit 7
// - overflow bit 6, discard new word
// - rx fifo empty when pointers equal
// - tx empty bit 3, resets high
// - standard mode tx full on load
// - enhanced tx full: write+1 equals read
// - standard mode rx full until read
// - enhanced rx full: write+1 equals read
// - unimplemented bits read zero
// - error events gated by enables
// - audio ignore options avoid halting
module ssf_status
    import ssf_pkg::*;
(
    input  wire logic                 clk_in,       // 100 MHz block clock
    input  wire logic                 rst_b_in,     // sync reset, active low
    input  wire logic                 ce_in,        // clock enable, freezes all
    input  wire logic                 psel_in,      // apb select
    input  wire logic                 penable_in,   // apb enable
    input  wire logic                 pwrite_in,    // apb direction
    input  wire logic [7:0]           paddr_in,     // apb byte address
    input  wire logic [31:0]          pwdata_in,    // apb write data
    output logic      [31:0]          prdata_out,   // apb read data
    output logic                      pready_out,   // apb ready
    output logic                      pslverr_out,  // apb error, unmapped
    input  wire logic                 sck_in,       // link clock pin
    input  wire logic                 fsync_in,     // link frame sync pin
    input  wire logic                 tx_load_in,   // core wrote data buffer
    input  wire logic                 tx_shift_in,  // word moved to shifter
    input  wire logic                 rx_shift_in,  // complete word received
    input  wire logic                 rx_read_in,   // core read data buffer
    output logic [SSF_PTR_W-1:0]      tx_wr_ptr_out, // tx write pointer
    output logic [SSF_PTR_W-1:0]      tx_rd_ptr_out, // shifter read pointer
    output logic [SSF_PTR_W-1:0]      rx_wr_ptr_out, // rx write pointer
    output logic [SSF_PTR_W-1:0]      rx_rd_ptr_out, // rx read pointer
    output logic                      halt_out,     // critical error stop
    output logic                      send_zeros_out, // underrun fill
    output logic                      irq_out       // level interrupt
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic [31:0]           ctrl_q;
    logic [SSF_EV_W-1:0]   ev_q;
    logic [SSF_EV_W-1:0]   mask_q;
    logic [SSF_PTR_W-1:0]  twp_q, srp_q, rwp_q, rrp_q;
    logic [SSF_PTR_W-1:0]  twp_d, srp_d;
    logic                  tx_empty_q, tx_full_q, rx_full_q;
    logic                  frm_err_q, tx_und_q, rx_ovf_q;
    logic                  shifter_full_q, busy_q;
    logic [SSF_BITCNT_W-1:0] bitcnt_q;
    logic [1:0]            link_s;
    logic                  sck_prev_q, fs_prev_q;
    logic                  sck_rise, fs_rise, word_done;
    logic                  on, enh, framed_enable, auden;
    logic                  tx_full_w, rx_full_w, rx_empty_w, tx_none_w;
    logic                  ovf_ev, und_ev, frm_ev;
    logic                  apb_setup, apb_wr, stat_wr;
    logic [31:0]           stat_w;
    logic [31:0]           rdata_d;
    logic                  err_d;

    assign on    = ctrl_q[SSF_ON_BIT];
    assign enh   = ctrl_q[SSF_ENH_BIT];
    assign framed_enable = ctrl_q[SSF_FRAMED_ENABLE_BIT];
    assign auden = ctrl_q[SSF_AUDEN_BIT];

    // ****************************************************************
    // link pins: synchronise, then find edges
    // ****************************************************************
    ssf_sync2 #(
        .WIDTH(2)
    ) u_sync (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .ce_in    (ce_in),
        .d_in     ({fsync_in, sck_in}),
        .q_out    (link_s)
    );

    // edge history runs off the second stage only
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            sck_prev_q <= 1'b0;
            fs_prev_q  <= 1'b0;
        end else if (ce_in) begin
            sck_prev_q <= link_s[0];
            fs_prev_q  <= link_s[1];
        end
    end

    assign sck_rise  = link_s[0] & ~sck_prev_q;
    assign fs_rise   = link_s[1] & ~fs_prev_q;
    assign word_done = sck_rise & (bitcnt_q == SSF_WORD_LAST);

    // bit position within a word; a frame sync restarts the word
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            bitcnt_q <= '0;
        end else if (ce_in) begin
            if (!on || fs_rise || word_done) begin
                bitcnt_q <= '0;
            end else if (sck_rise) begin
                bitcnt_q <= bitcnt_q + 5'h01;
            end
        end
    end

    // ****************************************************************
    // buffer state
    // ****************************************************************
    assign tx_full_w  = enh ? ((twp_q + 4'h1) == srp_q) : tx_full_q;
    assign rx_full_w  = enh ? ((rwp_q + 4'h1) == rrp_q) : rx_full_q;
    assign rx_empty_w = (rrp_q == rwp_q);
    assign tx_none_w  = enh ? (twp_q == srp_q) : tx_empty_q;

    // next tx pointers, used to settle the empty flag in enhanced mode
    always_comb begin
        twp_d = twp_q;
        srp_d = srp_q;
        if (enh && tx_load_in && !tx_full_w) begin
            twp_d = twp_q + 4'h1;
        end
        if (enh && tx_shift_in && !tx_none_w) begin
            srp_d = srp_q + 4'h1;
        end
    end

    // tx pointers and standard-mode tx flags; disable empties the buffer
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            twp_q      <= '0;
            srp_q      <= '0;
            tx_full_q  <= SSF_FLAG_RESET;
            tx_empty_q <= SSF_TBE_RESET;
        end else if (ce_in) begin
            if (!on) begin
                twp_q      <= '0;
                srp_q      <= '0;
                tx_full_q  <= SSF_FLAG_RESET;
                tx_empty_q <= SSF_TBE_RESET;
            end else if (enh) begin
                twp_q      <= twp_d;
                srp_q      <= srp_d;
                tx_empty_q <= (twp_d == srp_d);
            end else if (tx_load_in) begin
                tx_full_q  <= 1'b1;
                tx_empty_q <= 1'b0;
            end else if (tx_shift_in) begin
                tx_full_q  <= 1'b0;
                tx_empty_q <= 1'b1;
            end
        end
    end

    // rx side: a word arriving into a full buffer is dropped
    assign ovf_ev = on & rx_shift_in & rx_full_w;

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            rwp_q     <= '0;
            rrp_q     <= '0;
            rx_full_q <= SSF_FLAG_RESET;
        end else if (ce_in) begin
            if (!on) begin
                rwp_q     <= '0;
                rrp_q     <= '0;
                rx_full_q <= SSF_FLAG_RESET;
            end else if (enh) begin
                if (rx_shift_in && !rx_full_w) begin
                    rwp_q <= rwp_q + 4'h1;
                end
                if (rx_read_in && !rx_empty_w) begin
                    rrp_q <= rrp_q + 4'h1;
                end
            end else if (rx_shift_in && !rx_full_q) begin
                rx_full_q <= 1'b1;
            end else if (rx_read_in) begin
                rx_full_q <= 1'b0;
            end
        end
    end

    // shifter holds a word from tx_shift_in until the last link edge of it
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            shifter_full_q <= 1'b0;
            busy_q         <= 1'b0;
        end else if (ce_in) begin
            if (!on) begin
                shifter_full_q <= 1'b0;
            end else if (tx_shift_in) begin
                shifter_full_q <= 1'b1;
            end else if (word_done) begin
                shifter_full_q <= 1'b0;
            end
            busy_q <= on & (shifter_full_q | (bitcnt_q != '0) | ~tx_none_w);
        end
    end

    // ****************************************************************
    // sticky error flags
    // ****************************************************************
    // underrun: a frame starts with nothing to send
    assign und_ev  = on & framed_enable & fs_rise & tx_none_w;
    // frame error: a frame sync lands in the middle of a word
    assign frm_ev  = on & framed_enable & fs_rise & (bitcnt_q != '0);
    assign apb_wr  = psel_in & penable_in & pready_out & pwrite_in;
    assign stat_wr = apb_wr & (paddr_in == SSF_STAT_OFS);

    // set wins over a software clear in the same cycle; writing one keeps
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            frm_err_q <= SSF_FLAG_RESET;
            tx_und_q  <= SSF_FLAG_RESET;
            rx_ovf_q  <= SSF_FLAG_RESET;
        end else if (ce_in) begin
            if (!on) begin
                frm_err_q <= 1'b0;
                tx_und_q  <= 1'b0;
                rx_ovf_q  <= 1'b0;
            end else begin
                frm_err_q <= frm_ev | (frm_err_q & ~(stat_wr & ~pwdata_in[SSF_FRAME_ERROR_FLAG_BIT]));
                tx_und_q  <= und_ev | (tx_und_q & ~(stat_wr & ~pwdata_in[SSF_TUR_BIT]));
                rx_ovf_q  <= ovf_ev | (rx_ovf_q & ~(stat_wr & ~pwdata_in[SSF_ROV_BIT]));
            end
        end
    end

    // critical errors stop the link unless audio ignores them
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            halt_out       <= 1'b0;
            send_zeros_out <= 1'b0;
        end else if (ce_in) begin
            if (!on) begin
                halt_out       <= 1'b0;
                send_zeros_out <= 1'b0;
            end else begin
                if ((ovf_ev && !(auden && ctrl_q[SSF_IGNOV_BIT])) ||
                    (und_ev && !(auden && ctrl_q[SSF_IGNTU_BIT]))) begin
                    halt_out <= 1'b1;
                end
                if (und_ev && auden && ctrl_q[SSF_IGNTU_BIT]) begin
                    send_zeros_out <= 1'b1;
                end else if (tx_load_in) begin
                    send_zeros_out <= 1'b0;
                end
            end
        end
    end

    // ****************************************************************
    // events and interrupt
    // ****************************************************************
    // only enabled error kinds reach the sticky event bits
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            ev_q <= '0;
        end else if (ce_in) begin
            ev_q[SSF_EV_FRM] <= (frm_ev & ctrl_q[SSF_FEEN_BIT])
                | (ev_q[SSF_EV_FRM] & ~(apb_wr & (paddr_in == SSF_ISTAT_OFS)
                                        & pwdata_in[SSF_EV_FRM]));
            ev_q[SSF_EV_ROV] <= (ovf_ev & ctrl_q[SSF_OVEN_BIT])
                | (ev_q[SSF_EV_ROV] & ~(apb_wr & (paddr_in == SSF_ISTAT_OFS)
                                        & pwdata_in[SSF_EV_ROV]));
            ev_q[SSF_EV_TUR] <= (und_ev & ctrl_q[SSF_TUEN_BIT])
                | (ev_q[SSF_EV_TUR] & ~(apb_wr & (paddr_in == SSF_ISTAT_OFS)
                                        & pwdata_in[SSF_EV_TUR]));
        end
    end

    // interrupt follows the masked events one cycle later
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            irq_out <= 1'b0;
        end else if (ce_in) begin
            irq_out <= |(ev_q & mask_q);
        end
    end

    // ****************************************************************
    // apb slave
    // ****************************************************************
    // status word; everything not listed reads as zero
    always_comb begin
        stat_w = '0;
        stat_w[SSF_RXCNT_LSB +: SSF_CNT_W] = {1'b0, rwp_q - rrp_q};
        stat_w[SSF_TXCNT_LSB +: SSF_CNT_W] = {1'b0, twp_q - srp_q};
        stat_w[SSF_FRAME_ERROR_FLAG_BIT] = frm_err_q;
        stat_w[SSF_BUSY_BIT]   = busy_q;
        stat_w[SSF_TUR_BIT]    = tx_und_q;
        // fifo-side flags mean nothing in standard mode, so they read zero there
        stat_w[SSF_SHIFTER_EMPTY_FLAG_BIT]   = enh & ~shifter_full_q;
        stat_w[SSF_ROV_BIT]    = rx_ovf_q;
        stat_w[SSF_RBE_BIT]    = enh & rx_empty_w;
        stat_w[SSF_TBE_BIT]    = tx_empty_q;
        stat_w[SSF_TBF_BIT]    = tx_full_w;
        stat_w[SSF_RBF_BIT]    = rx_full_w;
    end

    assign apb_setup = psel_in & ~penable_in;

    // read mux, sampled in the setup cycle so the answer comes from flops
    always_comb begin
        rdata_d = '0;
        err_d   = 1'b0;
        unique case (paddr_in)
            SSF_STAT_OFS:  rdata_d = stat_w;
            SSF_CTRL_OFS:  rdata_d = ctrl_q;
            SSF_ISTAT_OFS: rdata_d = {29'h0, ev_q};
            SSF_IMASK_OFS: rdata_d = {29'h0, mask_q};
            default:       err_d   = 1'b1;
        endcase
    end

    // zero wait states: ready rises at the end of setup, falls after access
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            prdata_out  <= '0;
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
        end else if (ce_in) begin
            pready_out  <= apb_setup;
            pslverr_out <= apb_setup & err_d;
            if (apb_setup) begin
                prdata_out <= pwrite_in ? 32'h0000_0000 : rdata_d;
            end
        end
    end

    // writable registers; status bits other than clears are read-only
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            ctrl_q <= SSF_CTRL_RESET;
            mask_q <= '0;
        end else if (ce_in && apb_wr) begin
            if (paddr_in == SSF_CTRL_OFS) begin
                ctrl_q <= pwdata_in & SSF_CTRL_MASK;
            end
            if (paddr_in == SSF_IMASK_OFS) begin
                mask_q <= pwdata_in[SSF_EV_W-1:0];
            end
        end
    end

    assign tx_wr_ptr_out = twp_q;
    assign tx_rd_ptr_out = srp_q;
    assign rx_wr_ptr_out = rwp_q;
    assign rx_rd_ptr_out = rrp_q;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    ovf_discard_a: assert property (ce_in && on && rx_shift_in && rx_full_w && enh
        |=> rx_ovf_q && $stable(rwp_q)) else $error("overflow word not discarded");
    rx_empty_a: assert property (ce_in && on && enh && rx_shift_in && !rx_full_w
        && !rx_read_in |=> !rx_empty_w) else $error("rx empty after store");
    tx_full_std_a: assert property (ce_in && on && !enh && tx_load_in
        |=> tx_full_q) else $error("tx full not set by load");
    rx_full_std_a: assert property (ce_in && on && !enh && rx_read_in && !rx_shift_in
        |=> !rx_full_q) else $error("rx full not cleared by read");
    tbe_std_a: assert property (ce_in && on && !enh && tx_shift_in && !tx_load_in
        |=> tx_empty_q && !tx_full_q) else $error("tx empty not set on shift");
    ovf_keep_a: assert property (ce_in && on && rx_ovf_q && stat_wr
        && pwdata_in[SSF_ROV_BIT] |=> rx_ovf_q) else $error("overflow lost on write one");
    disable_clr_a: assert property (ce_in && !on
        |=> !tx_und_q && !rx_ovf_q && !frm_err_q && tx_empty_q) else $error("disable kept flags");
    ev_gate_a: assert property (ce_in && !ctrl_q[SSF_OVEN_BIT] && !ev_q[SSF_EV_ROV]
        |=> !ev_q[SSF_EV_ROV]) else $error("overflow event while disabled");
    reserved_a: assert property (pready_out && !pwrite_in && $past(paddr_in) == SSF_STAT_OFS
        |-> (prdata_out & SSF_STAT_RSVD) == 32'h0000_0000) else $error("reserved bit set");
    zeros_a: assert property (ce_in && on && und_ev && auden && ctrl_q[SSF_IGNTU_BIT]
        |=> send_zeros_out && !halt_out) else $error("ignored underrun halted");
    apb_ready_a: assert property (ce_in && apb_setup
        |=> pready_out) else $error("apb answer late");

    ovf_seen_c: cover property (ce_in && ovf_ev);
    und_seen_c: cover property (ce_in && und_ev);
    frm_seen_c: cover property (ce_in && frm_ev);
    irq_seen_c: cover property (irq_out);

endmodule

/* rtl/ssf_pkg.sv */
package ssf_pkg;

    // ****************************************************************
    // register map, byte addresses on the APB side
    // ****************************************************************
    localparam logic [7:0] SSF_STAT_OFS  = 8'h00;  // serial_status
    localparam logic [7:0] SSF_CTRL_OFS  = 8'h04;  // mode and enable bits
    localparam logic [7:0] SSF_ISTAT_OFS = 8'h08;  // sticky event bits, write one to clear
    localparam logic [7:0] SSF_IMASK_OFS = 8'h0C;  // event mask, same layout

    // ****************************************************************
    // serial_status field positions
    // ****************************************************************
    localparam int SSF_RXCNT_LSB  = 24;
    localparam int SSF_TXCNT_LSB  = 16;
    localparam int SSF_FRAME_ERROR_FLAG_BIT = 12;
    localparam int SSF_BUSY_BIT   = 11;
    localparam int SSF_TUR_BIT    = 8;
    localparam int SSF_SHIFTER_EMPTY_FLAG_BIT   = 7;
    localparam int SSF_ROV_BIT    = 6;
    localparam int SSF_RBE_BIT    = 5;
    localparam int SSF_TBE_BIT    = 3;
    localparam int SSF_TBF_BIT    = 1;
    localparam int SSF_RBF_BIT    = 0;
    localparam logic [31:0] SSF_STAT_RSVD = 32'hE0E0_E614;  // always read as zero

    // ****************************************************************
    // control register field positions
    // ****************************************************************
    localparam int SSF_ON_BIT     = 0;
    localparam int SSF_ENH_BIT    = 1;
    localparam int SSF_FRAMED_ENABLE_BIT  = 2;
    localparam int SSF_AUDEN_BIT  = 3;
    localparam int SSF_IGNTU_BIT  = 8;
    localparam int SSF_IGNOV_BIT  = 9;
    localparam int SSF_TUEN_BIT   = 10;
    localparam int SSF_OVEN_BIT   = 11;
    localparam int SSF_FEEN_BIT   = 12;
    localparam logic [31:0] SSF_CTRL_MASK  = 32'h0000_1F0F;
    localparam logic [31:0] SSF_CTRL_RESET = 32'h0000_0000;

    // ****************************************************************
    // event bits in the sticky status and mask registers
    // ****************************************************************
    localparam int SSF_EV_FRM = 0;
    localparam int SSF_EV_ROV = 1;
    localparam int SSF_EV_TUR = 2;
    localparam int SSF_EV_W   = 3;

    // ****************************************************************
    // sizes and reset values
    // ****************************************************************
    localparam int SSF_PTR_W      = 4;   // fifo pointer width
    localparam int SSF_CNT_W      = 5;   // element count width
    localparam int SSF_BITCNT_W   = 5;   // link bit counter width
    localparam logic [4:0] SSF_WORD_LAST = 5'h07;  // sck edges per word minus one
    localparam logic SSF_TBE_RESET = 1'b1;
    localparam logic SSF_FLAG_RESET = 1'b0;

endpackage

/* rtl/ssf_sync2.sv */
`timescale 1ns/100ps

// ********************************************************************
// two-stage synchroniser for link pins
// ********************************************************************
module ssf_sync2 #(
    parameter int WIDTH = 2
) (
    input  wire logic             clk_in,    // block clock
    input  wire logic             rst_b_in,  // sync reset, active low
    input  wire logic             ce_in,     // clock enable
    input  wire logic [WIDTH-1:0] d_in,      // asynchronous levels
    output logic      [WIDTH-1:0] q_out      // synchronised levels
);

    // first stage feeds only the second, never any logic
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            logic meta_q;
            logic sync_q;
            always_ff @(posedge clk_in) begin
                if (!rst_b_in) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else if (ce_in) begin
                    meta_q <= d_in[gi];
                    sync_q <= meta_q;
                end
            end
            assign q_out[gi] = sync_q;
        end
    endgenerate

endmodule

/* tb/ssf_link_model.sv */
`timescale 1ns/100ps
// ****************************************************************
// far-side framer: sck stands low between frames, 80 ns period
// ****************************************************************
module ssf_link_model (
    output logic sck_out,   // link clock pin
    output logic fsync_out  // frame sync pin
);
    initial begin
        sck_out = 1'b0;
        fsync_out = 1'b0;
    end
    // n link edges per frame; fewer than eight leaves a word cut short
    // pins move 2 ns off the block clock edge, sync stays low between frames
    task frame(input int n);
        #2 fsync_out = 1'b1;
        repeat (n) begin
            #40 sck_out = 1'b1;
            #40 sck_out = 1'b0;
        end
        fsync_out = 1'b0;
        #80;
    endtask
endmodule

/* tb/test_ssf_status.sv */
`timescale 1ns/100ps
// ****************************************************************
// status flag bench
// ****************************************************************
module test_ssf_status import ssf_pkg::*;;
    logic        clk_in, rst_b_in, psel, penable, pwrite, pready, se, irq, sck, fs;
    logic        ce, halt, zeros;
    logic [15:0] ptrs;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rv;
    logic [3:0]  ev;
    logic        pslverr;
    int          bad_count, num_checks;
    ssf_link_model lnk (.sck_out(sck), .fsync_out(fs));
    ssf_status dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .sck_in(sck),
        .fsync_in(fs), .tx_load_in(ev[0]), .tx_shift_in(ev[1]), .rx_shift_in(ev[2]),
        .rx_read_in(ev[3]), .tx_wr_ptr_out(ptrs[15:12]), .tx_rd_ptr_out(ptrs[11:8]),
        .rx_wr_ptr_out(ptrs[7:4]), .rx_rd_ptr_out(ptrs[3:0]), .halt_out(halt),
        .send_zeros_out(zeros), .irq_out(irq));
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    task results;
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    // one apb transfer; a hung slave ends the run
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            bad_count++;
            results();
        end
        rv = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_in);
        if (!w && a == SSF_STAT_OFS) chk("rsvd", 32'h0, rv & SSF_STAT_RSVD);
    endtask
    // one-cycle datapath pulse, then room for the flags to land
    task pulse(input logic [3:0] m);
        ev <= m;
        @(posedge clk_in);
        ev <= 4'h0;
        repeat (2) @(posedge clk_in);
    endtask
    task stat(input string nm, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, SSF_STAT_OFS, 32'h0);
        chk(nm, e, rv & m);
    endtask
    task irqchk(input logic e);
        repeat (2) @(posedge clk_in);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask
    task t_std;
        apb(1'b1, SSF_CTRL_OFS, 32'h1);
        // a load while the clock enable is low must leave no trace
        ce <= 1'b0;
        pulse(4'h1);
        ce <= 1'b1;
        stat("frozen", 32'hA, 32'h8);
        pulse(4'h1);
        stat("load", 32'hA, 32'h2);
        pulse(4'h2);
        stat("shift", 32'h80A, 32'h808);
        pulse(4'h4);
        stat("rxfull", 32'h1, 32'h1);
        pulse(4'h8);
        stat("rxread", 32'h1, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk("slverr", 32'h1, {31'h0, se});
    endtask
    task t_ovf;
        apb(1'b1, SSF_IMASK_OFS, 32'h2);
        apb(1'b1, SSF_CTRL_OFS, 32'h801);
        pulse(4'h4);
        pulse(4'h4);
        stat("ovf", 32'h41, 32'h41);
        irqchk(1'b1);
        apb(1'b1, SSF_STAT_OFS, 32'h40);
        stat("keep", 32'h40, 32'h40);
        apb(1'b1, SSF_STAT_OFS, 32'h0);
        stat("clr", 32'h40, 32'h0);
        apb(1'b1, SSF_IMASK_OFS, 32'h0);
        irqchk(1'b0);
        apb(1'b1, SSF_ISTAT_OFS, 32'h2);
        apb(1'b1, SSF_IMASK_OFS, 32'h2);
        irqchk(1'b0);
    endtask
    // fill both fifos to fifteen entries, then overflow and drain one tx word
    task t_enh;
        apb(1'b1, SSF_CTRL_OFS, 32'h0);
        apb(1'b1, SSF_CTRL_OFS, 32'h3);
        pulse(4'h1);
        pulse(4'h1);
        pulse(4'h4);
        stat("enh", 32'h1F1F_08A3, 32'h0102_0880);
        repeat (14) pulse(4'h5);
        stat("full", 32'h1F1F_0023, 32'h0F0F_0003);
        pulse(4'h4);
        stat("eovf", 32'h1F00_0041, 32'h0F00_0041);
        pulse(4'h2);
        stat("shifter_empty_flag", 32'h001F_0082, 32'h000E_0000);
        chk("ptrs", 32'h0000_F1F0, {16'h0, ptrs});
    endtask
    // a cut word then a full frame: underrun and frame error; then audio ignore
    task t_tur;
        apb(1'b1, SSF_CTRL_OFS, 32'h0);
        apb(1'b1, SSF_CTRL_OFS, 32'h5);
        lnk.frame(3);
        lnk.frame(8);
        repeat (10) @(posedge clk_in);
        stat("tur", 32'h1100, 32'h1100);
        chk("halt", 32'h1, {31'h0, halt});
        apb(1'b1, SSF_CTRL_OFS, 32'h0);
        apb(1'b1, SSF_CTRL_OFS, 32'h10D);
        lnk.frame(8);
        repeat (10) @(posedge clk_in);
        chk("zeros", 32'h1, {30'h0, halt, zeros});
        pulse(4'h1);
        chk("refill", 32'h0, {31'h0, zeros});
    endtask
    initial begin
        {rst_b_in, psel, penable, pwrite, paddr, pwdata, ev} = '0;
        ce = 1'b1;
        bad_count = 0;
        num_checks = 0;
        repeat (5) @(posedge clk_in);
        rst_b_in <= 1'b1;
        @(posedge clk_in);
        stat("reset", 32'hFFFF_FFFF, 32'h8);
        t_std;
        t_ovf;
        t_enh;
        t_tur;
        results;
    end
endmodule
